// ===== cpw_consts.vh
`ifndef CPW_CONSTS_VH
`define CPW_CONSTS_VH

// Register byte offsets on the APB slave
`define CPW_OFF_CTRL    8'h00
`define CPW_OFF_RUN     8'h04
`define CPW_OFF_STAT    8'h08
`define CPW_OFF_PERIOD  8'h0C
`define CPW_OFF_DUTY1   8'h10
`define CPW_OFF_DUTY2   8'h14
`define CPW_OFF_DUTY3   8'h18
`define CPW_OFF_BUF1    8'h1C
`define CPW_OFF_BUF2    8'h20
`define CPW_OFF_BUF3    8'h24
`define CPW_OFF_CNT1    8'h28
`define CPW_OFF_CNT2    8'h2C
`define CPW_OFF_DEAD    8'h30

// Control register fields
`define CPW_CTRL_MODE_LO  0
`define CPW_CTRL_MODE_HI  1
`define CPW_CTRL_OLSP     2
`define CPW_CTRL_OLSN     3
`define CPW_CTRL_BFE_LO   4
`define CPW_CTRL_BFE_HI   6

// Run register fields
`define CPW_RUN_FIRST   0
`define CPW_RUN_SECOND  1

// Status register fields
`define CPW_STAT_PEAK   0
`define CPW_STAT_UDF    1
`define CPW_STAT_OVF    2

// Mode field codes
`define CPW_MODE_PLAIN  2'h0
`define CPW_MODE_VALLEY 2'h2
`define CPW_MODE_PEAK   2'h3

// Per-phase transfer history
`define CPW_HIST_NORM   2'h0
`define CPW_HIST_HIGH   2'h1
`define CPW_HIST_ZERO   2'h2

// Reset values
`define CPW_RST_PERIOD  16'hFFFF
`define CPW_RST_DEAD    16'h0000
`define CPW_RST_ZERO    16'h0000

`endif

// ===== cpw_pwm_core.v
//
// Contract
// - Duty registers change only by buffer copy while running; direct writes take while stopped.
// - Period fixed during operation; duty only changes.
// - First counter turns m-1, m, m+1, m.
// - Peak flag set stepping m to m+1.
// - Mode 11b copies buffers at peak.
// - Peak turn: no flag change, no transfer.
// - Second counter turns 1, 0, FFFFh, 0.
// - Underflow flag set passing 0 to FFFFh.
// - Mode 10b copies buffers at underflow.
// - Valley turn: no transfer, overflow unchanged.
// - Buffer at or above period: valley transfer.
// - Next normal value after that: valley once.
// - Zero buffer: transfer at peak match.
// - Next normal value after zero: peak once.
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`include "cpw_consts.vh"

module cpw_pwm_core #(
  parameter W = 16
) (
  input  wire         clock,
  input  wire         rst_n,
  input  wire         clkEn,
  input  wire         psel,
  input  wire         penable,
  input  wire         pwrite,
  input  wire [7:0]   paddr,
  input  wire [31:0]  pwdata,
  output wire [31:0]  prdata,
  output wire         pready,
  output wire         pslverr,
  output reg  [2:0]   pwmPosOut,
  output reg  [2:0]   pwmNegOut
);

  localparam [W-1:0] ALL_ONES = {W{1'b1}};
  localparam [W-1:0] ONE      = {{(W-1){1'b0}}, 1'b1};

  // Software-visible state, plus the internal per-phase transfer history histQ
  reg  [1:0]   modeQ;
  reg          olsPosQ;
  reg          olsNegQ;
  reg  [2:0]   bufEnQ;
  reg          runFirstQ;
  reg          runSecondQ;
  reg          peakFlagQ;
  reg          udfFlagQ;
  reg          ovfFlagQ;
  reg  [W-1:0] periodQ;
  reg  [W-1:0] deadQ;
  reg  [W-1:0] dutyQ [0:2];
  reg  [W-1:0] bufQ  [0:2];
  reg  [1:0]   histQ [0:2];

  // Carrier state
  reg  [W-1:0] cntFirstQ;
  reg  [W-1:0] cntSecondQ;
  reg          dirUpQ;

  reg  [31:0]  rdData;
  reg          mapped;
  integer      k;

  wire         access  = psel & penable;
  wire         wrStb   = access & pwrite & clkEn;
  wire         complMode = (modeQ == `CPW_MODE_VALLEY) | (modeQ == `CPW_MODE_PEAK);
  wire         running = runFirstQ & runSecondQ & complMode;

  // Carrier walk with period value m and dead time d:
  //   first counter  d, d+1 .. m, m+1, m .. d, d-1, d ..
  //   second counter 0, 1 .. m-d+1, m-d .. 1, 0, FFFFh, 0 ..
  // The first counter leads the second by d on the way up,
  // and both turn on the same edge, so one direction bit serves.
  // Peak event only on the step from m to m+1.
  // Underflow event only on the step from 0 to FFFFh.
  // The steps that follow a turn raise no event and move no data.
  // Limitation: d must stay below m; the logic does not check it,
  // a larger dead time would let the valley wrap before the peak.
  // Trade-off: m+1 is formed in W bits, so an all-ones period
  // wraps its turning point to zero; software keeps m below that.
  // Period, dead time and duty writes are refused while running,
  // so the waveform can only move through the buffer copies.

  // Counter decodes shared by the events and the carrier
  wire [W-1:0] peakTop  = periodQ + ONE;                 // Turning point m+1
  wire         c1AtPer  = (cntFirstQ == periodQ);        // Last count before the turn
  wire         c1AtTop  = (cntFirstQ == peakTop);        // Turning count
  wire         c2AtZero = (cntSecondQ == `CPW_RST_ZERO); // Last count before the wrap
  wire         c2AtWrap = (cntSecondQ == ALL_ONES);      // Wrapped valley count

  // Status write-one-to-clear strobes
  wire         statWr   = wrStb & (paddr == `CPW_OFF_STAT);
  wire         clrPeak  = statWr & pwdata[`CPW_STAT_PEAK];
  wire         clrUdf   = statWr & pwdata[`CPW_STAT_UDF];
  wire         clrOvf   = statWr & pwdata[`CPW_STAT_OVF];

  // Carrier events, one cycle each; the turning steps raise none
  wire peakEvt = running & dirUpQ & c1AtPer;
  wire udfEvt  = running & ~dirUpQ & c2AtZero;
  // Overflow would need an up count past all-ones, which the
  // turn at m+1 prevents; kept so the flag has a defined source
  wire ovfEvt  = running & dirUpQ & ~c1AtTop & c2AtWrap;

  // APB: always ready in one access cycle, error on unmapped offsets
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata  = rdData;

  // Read mux; reserved bits read as zero
  always @* begin
    rdData = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      `CPW_OFF_CTRL: begin
        rdData[`CPW_CTRL_MODE_HI:`CPW_CTRL_MODE_LO] = modeQ;
        rdData[`CPW_CTRL_OLSP] = olsPosQ;
        rdData[`CPW_CTRL_OLSN] = olsNegQ;
        rdData[`CPW_CTRL_BFE_HI:`CPW_CTRL_BFE_LO] = bufEnQ;
      end
      `CPW_OFF_RUN: begin
        rdData[`CPW_RUN_FIRST]  = runFirstQ;
        rdData[`CPW_RUN_SECOND] = runSecondQ;
      end
      `CPW_OFF_STAT: begin
        rdData[`CPW_STAT_PEAK] = peakFlagQ;
        rdData[`CPW_STAT_UDF]  = udfFlagQ;
        rdData[`CPW_STAT_OVF]  = ovfFlagQ;
      end
      `CPW_OFF_PERIOD: rdData[W-1:0] = periodQ;
      `CPW_OFF_DUTY1:  rdData[W-1:0] = dutyQ[0];
      `CPW_OFF_DUTY2:  rdData[W-1:0] = dutyQ[1];
      `CPW_OFF_DUTY3:  rdData[W-1:0] = dutyQ[2];
      `CPW_OFF_BUF1:   rdData[W-1:0] = bufQ[0];
      `CPW_OFF_BUF2:   rdData[W-1:0] = bufQ[1];
      `CPW_OFF_BUF3:   rdData[W-1:0] = bufQ[2];
      `CPW_OFF_CNT1:   rdData[W-1:0] = cntFirstQ;
      `CPW_OFF_CNT2:   rdData[W-1:0] = cntSecondQ;
      `CPW_OFF_DEAD:   rdData[W-1:0] = deadQ;
      default:         mapped = 1'b0;
    endcase
  end

  // Control, run and dead-time registers
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      modeQ      <= `CPW_MODE_PLAIN;
      olsPosQ    <= 1'b0;
      olsNegQ    <= 1'b0;
      bufEnQ     <= 3'h0;
      runFirstQ  <= 1'b0;
      runSecondQ <= 1'b0;
      deadQ      <= `CPW_RST_DEAD;
    end else if (wrStb) begin
      case (paddr)
        `CPW_OFF_CTRL: begin
          modeQ   <= pwdata[`CPW_CTRL_MODE_HI:`CPW_CTRL_MODE_LO];
          olsPosQ <= pwdata[`CPW_CTRL_OLSP];
          olsNegQ <= pwdata[`CPW_CTRL_OLSN];
          bufEnQ  <= pwdata[`CPW_CTRL_BFE_HI:`CPW_CTRL_BFE_LO];
        end
        `CPW_OFF_RUN: begin
          runFirstQ  <= pwdata[`CPW_RUN_FIRST];
          runSecondQ <= pwdata[`CPW_RUN_SECOND];
        end
        // Dead time only takes while stopped, it sets the counter offset
        `CPW_OFF_DEAD: if (!running) deadQ <= pwdata[W-1:0];
        default: ;
      endcase
    end
  end

  // Status flags: write one to clear, a same-cycle event wins
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      peakFlagQ <= 1'b0;
      udfFlagQ  <= 1'b0;
      ovfFlagQ  <= 1'b0;
    end else if (clkEn) begin
      // Set before clear, so an event is never lost to a late clear
      if (peakEvt)
        peakFlagQ <= 1'b1;
      else if (clrPeak)
        peakFlagQ <= 1'b0;
      if (udfEvt)
        udfFlagQ <= 1'b1;
      else if (clrUdf)
        udfFlagQ <= 1'b0;
      if (ovfEvt)
        ovfFlagQ <= 1'b1;
      else if (clrOvf)
        ovfFlagQ <= 1'b0;
    end
  end

  // Period register: frozen while the carrier runs
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      periodQ <= `CPW_RST_PERIOD;
    end else if (wrStb && paddr == `CPW_OFF_PERIOD && !running) begin
      periodQ <= pwdata[W-1:0];
    end
  end

  // Carrier: one direction bit steers both counters together
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cntFirstQ  <= `CPW_RST_ZERO;
      cntSecondQ <= `CPW_RST_ZERO;
      dirUpQ     <= 1'b1;
    end else if (clkEn) begin
      if (!running) begin
        // Stopped: preload so the first leads the second by the dead time
        cntFirstQ  <= deadQ;
        cntSecondQ <= `CPW_RST_ZERO;
        dirUpQ     <= 1'b1;
      end else if (dirUpQ) begin
        if (c1AtTop) begin
          dirUpQ     <= 1'b0;
          cntFirstQ  <= cntFirstQ - ONE;
          cntSecondQ <= cntSecondQ - ONE;
        end else begin
          cntFirstQ  <= cntFirstQ + ONE;
          cntSecondQ <= cntSecondQ + ONE;
        end
      end else begin
        if (c2AtWrap) begin
          dirUpQ     <= 1'b1;
          cntFirstQ  <= cntFirstQ + ONE;
          cntSecondQ <= cntSecondQ + ONE;
        end else begin
          cntFirstQ  <= cntFirstQ - ONE;
          cntSecondQ <= cntSecondQ - ONE;
        end
      end
    end
  end

  // Buffer and duty registers per phase
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gPhase
      wire [7:0] dutyOff = `CPW_OFF_DUTY1 + 8'h04 * g;
      wire [7:0] bufOff  = `CPW_OFF_BUF1 + 8'h04 * g;
      wire       isHigh  = (bufQ[g] >= periodQ);
      wire       isZero  = (bufQ[g] == `CPW_RST_ZERO);
      reg        atPeak;
      reg        atValley;

      // Transfer timing: special values override the mode field
      always @* begin
        atPeak   = 1'b0;
        atValley = 1'b0;
        if (isHigh)
          atValley = 1'b1;
        else if (isZero)
          atPeak = 1'b1;
        else if (histQ[g] == `CPW_HIST_HIGH)
          atValley = 1'b1;
        else if (histQ[g] == `CPW_HIST_ZERO)
          atPeak = 1'b1;
        else if (modeQ == `CPW_MODE_PEAK)
          atPeak = 1'b1;
        else
          atValley = 1'b1;
      end

      wire doXfer = bufEnQ[g] & ((atPeak & peakEvt) | (atValley & udfEvt));

      always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          dutyQ[g] <= `CPW_RST_ZERO;
          bufQ[g]  <= `CPW_RST_ZERO;
          histQ[g] <= `CPW_HIST_NORM;
        end else if (clkEn) begin
          if (wrStb && paddr == bufOff)
            bufQ[g] <= pwdata[W-1:0];
          if (doXfer) begin
            // Running duty values come from the buffer and nowhere else
            dutyQ[g] <= bufQ[g];
            histQ[g] <= isHigh ? `CPW_HIST_HIGH :
                        (isZero ? `CPW_HIST_ZERO : `CPW_HIST_NORM);
          end else if (wrStb && paddr == dutyOff && !running) begin
            dutyQ[g] <= pwdata[W-1:0];
          end
          if (!running)
            histQ[g] <= `CPW_HIST_NORM;
        end
      end

    end
  endgenerate

  // Outputs: active phases inverted from the initial level; the
  // dead-time lead keeps positive and negative from overlapping.
  // One process for all phases, so every output has one driver.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pwmPosOut <= 3'h0;
      pwmNegOut <= 3'h0;
    end else if (clkEn) begin
      for (k = 0; k < 3; k = k + 1) begin
        if (!running) begin
          // Stopped: every phase parks at its initial level
          pwmPosOut[k] <= olsPosQ;
          pwmNegOut[k] <= olsNegQ;
        end else begin
          // Positive active above duty, blanked on the valley wrap
          pwmPosOut[k] <= ((cntSecondQ > dutyQ[k]) & ~c2AtWrap) ? ~olsPosQ : olsPosQ;
          // Negative active below duty on the leading counter
          pwmNegOut[k] <= (cntFirstQ < dutyQ[k]) ? ~olsNegQ : olsNegQ;
        end
      end
    end
  end

endmodule // cpw_pwm_core

// ===== cpw_pwm_asserts.sv
`timescale 1ns/10ps
module cpw_pwm_asserts #(parameter W = 16) (
  input wire        clock,
  input wire        rst_n,
  input wire        clkEn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [2:0]  pwmPosOut,
  input wire [2:0]  pwmNegOut
);
  reg  [1:0]  runQ;
  reg  [1:0]  modeQ;
  reg  [15:0] perQ;
  wire        acc = psel && penable;
  wire        live = runQ == 2'h3 && modeQ[1];
  wire [16:0] rd = {1'h0, prdata[15:0]};
  wire [16:0] top = {1'h0, perQ} + 17'h1;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Shadow run state; period follows writes taken only while stopped
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {runQ, modeQ, perQ} <= {4'h0, 16'hFFFF};
    end else if (acc && pwrite && clkEn) begin
      if (paddr == 8'h04) runQ <= pwdata[1:0];
      if (paddr == 8'h00) modeQ <= pwdata[1:0];
      if (paddr == 8'h0C && !live) perQ <= pwdata[15:0];
    end
  end
  a_ready_high: assert property (psel |-> pready) else $error("pready low");
  a_err_unmapped: assert property (acc && paddr > 8'h30 |-> pslverr) else $error("no slave error");
  a_err_mapped: assert property (acc && paddr < 8'h34 && paddr[1:0] == 2'h0 |-> !pslverr) else $error("bad error");
  a_period_fixed: assert property (acc && paddr == 8'h0C && live |-> rd + 17'h1 == top)
    else $error("period moved");
  a_cnt1_bound: assert property (acc && paddr == 8'h28 && live |-> rd <= top)
    else $error("counter one too high");
  a_cnt2_bound: assert property (acc && paddr == 8'h2C && live |-> rd <= top || rd == 17'hFFFF)
    else $error("counter two out of range");
  a_stat_clean: assert property (acc && paddr == 8'h08 |-> prdata[31:2] == 30'h0)
    else $error("overflow flag set");
  a_stop_cnt2: assert property (acc && paddr == 8'h2C && !live && !$past(live) && $past(clkEn) |-> rd == 17'h0)
    else $error("counter two not parked");
endmodule // cpw_pwm_asserts

// ===== tb_cpw_pwm_core.sv
`timescale 1ns/10ps
module tb_cpw_pwm_core;
  reg         clock = 1'b0;
  reg         rst_n = 1'b0;
  reg         clkEn = 1'b1;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire        pready, pslverr;
  wire [2:0]  pwmPosOut, pwmNegOut;
  integer     bad_count = 0, comparisons = 0, seed = 57249, k, md;
  reg  [31:0] rdat, ex, cw;
  reg         rerr, up;
  reg  [15:0] per, dead, c1, c2, duty [0:2], bufr [0:2];
  reg  [15:0] m = 16'h0006;
  reg  [1:0]  hist [0:2], runr;
  reg  [6:0]  ctl;
  reg  [2:0]  stat, eP, eN;
  cpw_pwm_core #(.W(16)) cpw_pwm_core_inst (.*);
  always #4 clock = ~clock;
  // Reference model on the design's edges; history says how the last copy went
  always @(posedge clock or negedge rst_n) begin : model
    integer g;
    reg act, pk, ud, we, nu;
    if (!rst_n) begin
      {per, dead, c1, c2, ctl, runr, stat, up, eP, eN} <= {16'hFFFF, 60'h0, 1'b1, 6'h0};
      for (g = 0; g < 3; g = g + 1) {duty[g], bufr[g], hist[g]} <= 34'h0;
    end else if (clkEn) begin
      act = runr == 2'h3 && ctl[1];
      pk = act && up && c1 == per;
      ud = act && !up && c2 == 16'h0000;
      we = psel && penable && pwrite;
      nu = up ? c1 != per + 16'h0001 : c2 == 16'hFFFF;
      c1 <= !act ? dead : nu ? c1 + 16'h0001 : c1 - 16'h0001;
      c2 <= !act ? 16'h0000 : nu ? c2 + 16'h0001 : c2 - 16'h0001;
      up <= !act || nu;
      stat <= (we && paddr == 8'h08 ? stat & ~pwdata[2:0] : stat) | {1'b0, ud, pk};
      if (we && paddr == 8'h00) ctl <= pwdata[6:0];
      if (we && paddr == 8'h04) runr <= pwdata[1:0];
      if (we && !act && paddr == 8'h0C) per <= pwdata[15:0];
      if (we && !act && paddr == 8'h30) dead <= pwdata[15:0];
      for (g = 0; g < 3; g = g + 1) begin
        eP[g] <= act && c2 > duty[g] && c2 != 16'hFFFF ? ~ctl[2] : ctl[2];
        eN[g] <= act && c1 < duty[g] ? ~ctl[3] : ctl[3];
        if (we && paddr == 8'h1C + 4 * g) bufr[g] <= pwdata[15:0];
        if (we && !act && paddr == 8'h10 + 4 * g) duty[g] <= pwdata[15:0];
        if (!act) hist[g] <= 2'h0;
        else if (ctl[4 + g] && (bufr[g] >= per ? ud : bufr[g] == 16'h0 ? pk : hist[g] == 2'h1 ? ud :
                 hist[g] == 2'h2 ? pk : ctl[0] ? pk : ud)) begin
          duty[g] <= bufr[g];
          hist[g] <= bufr[g] >= per ? 2'h1 : bufr[g] == 16'h0 ? 2'h2 : 2'h0;
        end
      end
    end
  end
  function [31:0] mrd(input [7:0] a);
    case (a)
      8'h00: mrd = {25'h0, ctl};
      8'h04: mrd = {30'h0, runr};
      8'h08: mrd = {29'h0, stat};
      8'h0C: mrd = {16'h0, per};
      8'h10, 8'h14, 8'h18: mrd = {16'h0, duty[(a - 8'h10) >> 2]};
      8'h1C, 8'h20, 8'h24: mrd = {16'h0, bufr[(a - 8'h1C) >> 2]};
      8'h28: mrd = {16'h0, c1};
      8'h2C: mrd = {16'h0, c2};
      8'h30: mrd = {16'h0, dead};
      default: mrd = 32'h0;
    endcase
  endfunction
  task chk(input [47:0] nm, input [31:0] e, input [31:0] s);
    begin
      comparisons = comparisons + 1;
      if (s !== e) bad_count = bad_count + 1;
      if (s !== e) $display("[ERR] %0s expected %h seen %h", nm, e, s);
    end
  endtask
  // One transfer; the spare edge after release keeps psel from toggling twice in a step
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      {psel, penable, pwrite, paddr, pwdata, clkEn} <= {2'b10, w, a, d, 1'b1};
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge clock);
        n = n + 1;
      end while (pready !== 1'b1 && n < 50);
      {ex, rdat, rerr} = {mrd(a), prdata, pslverr};
      {psel, penable} <= 2'b00;
      @(posedge clock);
    end
  endtask
  task rdc(input [7:0] a);
    begin
      apb(1'b0, a, 32'h0);
      chk("rdata", ex, rdat);
      chk("slverr", {31'h0, a > 8'h30}, {31'h0, rerr});
    end
  endtask
  // Random clock-enable gaps freeze both sides alike
  task idle(input integer n);
    repeat (n) begin
      clkEn <= {$random(seed)} % 8 != 0;
      @(posedge clock);
    end
  endtask
  function [15:0] tbl(input integer j);
    case (j % 6)
      0: tbl = 16'h0000;
      1: tbl = m;
      2: tbl = m + 16'h0003;
      3: tbl = 16'h0001;
      4: tbl = m - 16'h0001;
      default: tbl = 16'h0002;
    endcase
  endfunction
  // Phase outputs checked every cycle at the settled falling edge
  always @(negedge clock) begin
    if (rst_n) chk("pos", {29'h0, eP}, {29'h0, pwmPosOut});
    if (rst_n) chk("neg", {29'h0, eN}, {29'h0, pwmNegOut});
  end
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    for (k = 0; k < 14; k = k + 1) rdc(k * 4);
    $display("test register map done");
    for (md = 3; md > 1; md = md - 1) begin
      cw = md | (md == 2 ? 32'hC : 32'h0);
      apb(1'b1, 8'h04, 32'h0);
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h00, cw);
      apb(1'b1, 8'h0C, m);
      apb(1'b1, 8'h30, 32'h1);
      for (k = 0; k < 6; k = k + 1) apb(1'b1, 8'h10 + 4 * k, k + 2);
      apb(1'b1, 8'h00, cw | 32'h70);
      apb(1'b1, 8'h04, 32'h3);
      for (k = 0; k < 24; k = k + 1) begin
        apb(1'b1, 8'h00, cw);
        apb(1'b1, 8'h1C + 4 * (k % 3), tbl(k));
        apb(1'b1, 8'h00, cw | 32'h70);
        apb(1'b1, 8'h0C, 32'h9);
        idle({$random(seed)} % 24);
        rdc(8'h08 + 4 * ({$random(seed)} % 10));
        rdc(8'h10 + 4 * (k % 3));
        apb(1'b1, 8'h08, 32'h7);
      end
      apb(1'b1, 8'h04, 32'h0);
      apb(1'b1, 8'h00, 32'h0);
      idle(4);
      rdc(8'h2C);
      $display("test mode %0d done", md);
    end
    complete_run;
  end
  initial begin
    #100000;
    bad_count = bad_count + 1;
    complete_run;
  end
  task complete_run;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
endmodule // tb_cpw_pwm_core
bind cpw_pwm_core cpw_pwm_asserts #(.W(W)) cpw_pwm_asserts_inst (.*);
